// ---- rtl/evstat_pkg.sv ----
/*
 * evstat_pkg: constants and carrier types for the event status register bank.
 * assumes: one core clock, command decoding done upstream of the bank.
 */
package evstat_pkg;
   // ----------------------------------------------------------------
   // register geometry
   // ----------------------------------------------------------------
   localparam int          REG_W     = 16;        // event and mask width
   localparam int          BCD_W     = 20;        // five decimal digits
   localparam int          BCD_DIG   = 5;         // digits in an answer
   localparam int          CODE_W    = 8;         // error code width
   localparam int          QDEPTH    = 15;        // error queue entries
   localparam int          QCNT_W    = 4;         // queue fill count width
   localparam logic [3:0]  QDEPTH_C  = 4'hF;      // depth at count width
   // ----------------------------------------------------------------
   // event bit positions
   // ----------------------------------------------------------------
   localparam int          BIT_OPC   = 0;         // operation complete
   localparam int          BIT_QYE   = 2;         // query error
   localparam int          BIT_DDE   = 3;         // device-dependent error
   localparam int          BIT_EXE   = 4;         // execution error
   localparam int          BIT_CME   = 5;         // command error
   localparam int          BIT_PON   = 7;         // power cycled
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] EVENT_RST = 16'h0000;  // event register at power-up
   localparam logic [15:0] MASK_RST  = 16'h0000;  // enable mask at power-up
   localparam logic [15:0] LIVE_MSK  = 16'h00BD;  // bits that can ever be one
   localparam logic [7:0]  CODE_NONE = 8'h00;     // fetch answer when queue empty

   // error and condition strobes from the remote interface
   typedef struct packed {
      logic cmd_err;      // malformed command
      logic exe_err;      // execution error
      logic dev_err;      // device-dependent error
      logic talk_empty;   // told to talk with nothing pending
      logic unread_lost;  // output queue data left unread
   } event_in_s;

   // whole state of the bank
   typedef struct packed {
      logic [15:0]             event_status;         // latched events
      logic [15:0]             event_status_enable;  // enable mask
      logic [QDEPTH-1:0][7:0]  queue;                // entry 0 is oldest
      logic [3:0]              qcount;               // entries held
      logic                    opc_armed;            // waiting for completion
      logic                    pwr_meta;             // sync stage one
      logic                    pwr_sync;             // sync stage two
      logic [19:0]             ans_bcd;              // decimal answer
      logic                    ans_valid;            // answer strobe
      logic [7:0]              err_code;             // fetched code
      logic                    err_valid;            // fetch strobe
      logic                    summary;              // event summary bit
   } bank_s;
endpackage

// ---- rtl/event_status_register_bank.sv ----
/*
 * event_status_register_bank: event register, enable mask, error queue,
 * decimal read answers and the event summary bit.
 * assumes: read/write/fetch strobes are one-cycle pulses from the command
 * decoder on CORE_CLK; PWR_CYCLED is an asynchronous level from the supply.
 */
`timescale 1ns/10ps

// Summary of operation
// - power cycle sets bit 7
// - malformed command sets bit 5
// - queue first 15 errors, oldest first
// - device-dependent error sets bit 3
// - talk-empty or unread output sets bit 2
// - operation complete sets bit 0
// - reading event register clears it
// - reading enable mask keeps it
// - reads answer as decimal of 16 bits
// - upper eight event bits read zero
// - event register zero at power-up
// - enable mask zero at power-up
// - summary bit from enabled set events
module event_status_register_bank (
   // clock and reset
   input  wire logic                        CORE_CLK,
   input  wire logic                        RSTN,
   // condition inputs
   input  wire logic                        PWR_CYCLED,
   input  wire evstat_pkg::event_in_s       EVENTS,
   input  wire logic                        OPC_CMD,
   input  wire logic                        EXEC_IDLE,
   input  wire logic                        IF_READY,
   // register queries
   input  wire logic                        EVENT_READ,
   input  wire logic                        MASK_READ,
   input  wire logic                        MASK_WRITE,
   input  wire logic [15:0]                 MASK_WDATA,
   input  wire logic                        CLEAR_STATUS,
   // error queue
   input  wire logic                        ERR_PUSH,
   input  wire logic [7:0]                  ERR_CODE_IN,
   input  wire logic                        ERR_FETCH,
   // answers
   output logic [19:0]                      ANS_BCD,
   output logic                             ANS_VALID,
   output logic [7:0]                       ERR_CODE,
   output logic                             ERR_VALID,
   output logic                             EVENT_SUMMARY
);
   import evstat_pkg::*;

   // ----------------------------------------------------------------
   // state and helpers
   // ----------------------------------------------------------------
   bank_s       state_reg;   // registered state
   bank_s       state_next;  // next state
   logic [15:0] set_vec;     // events raised this cycle
   logic        opc_fire;    // completion reached this cycle

   // binary to packed decimal, shift-and-add-three
   function automatic logic [19:0] to_bcd(input logic [15:0] bin);
      logic [35:0] s;
      s = {20'h00000, bin};
      for (int i = 0; i < REG_W; i++)
      begin
         for (int d = 0; d < BCD_DIG; d++)
         begin
            if (s[REG_W + 4*d +: 4] >= 4'h5)
            begin
               s[REG_W + 4*d +: 4] = s[REG_W + 4*d +: 4] + 4'h3;
            end
         end
         s = s << 1;
      end
      return s[35:16];
   endfunction

   // ----------------------------------------------------------------
   // event sources
   // ----------------------------------------------------------------
   // gather this cycle's event conditions into bit positions
   always_comb
   begin
      opc_fire         = state_reg.opc_armed && EXEC_IDLE && IF_READY;
      set_vec          = 16'h0000;
      set_vec[BIT_PON] = state_reg.pwr_sync;
      set_vec[BIT_CME] = EVENTS.cmd_err;
      set_vec[BIT_EXE] = EVENTS.exe_err;
      set_vec[BIT_DDE] = EVENTS.dev_err;
      set_vec[BIT_QYE] = EVENTS.talk_empty || EVENTS.unread_lost;
      set_vec[BIT_OPC] = opc_fire;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      state_next           = state_reg;
      state_next.ans_valid = 1'b0;
      state_next.err_valid = 1'b0;
      // supply level synchroniser
      state_next.pwr_meta  = PWR_CYCLED;
      state_next.pwr_sync  = state_reg.pwr_meta;
      // completion tracking
      if (OPC_CMD)
      begin
         state_next.opc_armed = 1'b1;
      end
      else if (opc_fire)
      begin
         state_next.opc_armed = 1'b0;
      end
      // reads answer the current value, decimal
      if (EVENT_READ)
      begin
         state_next.ans_bcd   = to_bcd(state_reg.event_status);
         state_next.ans_valid = 1'b1;
      end
      else if (MASK_READ)
      begin
         state_next.ans_bcd   = to_bcd(state_reg.event_status_enable);
         state_next.ans_valid = 1'b1;
      end
      // clear on read or clear-status, then new events win
      if (EVENT_READ || CLEAR_STATUS)
      begin
         state_next.event_status = EVENT_RST;
      end
      state_next.event_status = (state_next.event_status | set_vec) & LIVE_MSK;
      // mask write
      if (MASK_WRITE)
      begin
         state_next.event_status_enable = MASK_WDATA;
      end
      // error queue: fetch pops oldest, push keeps only first entries
      if (ERR_FETCH)
      begin
         state_next.err_valid = 1'b1;
         state_next.err_code  = (state_reg.qcount != 4'h0) ? state_reg.queue[0] : CODE_NONE;
         if (state_reg.qcount != 4'h0)
         begin
            for (int k = 0; k < QDEPTH - 1; k++)
            begin
               state_next.queue[k] = state_reg.queue[k + 1];
            end
            state_next.queue[QDEPTH - 1] = CODE_NONE;
            state_next.qcount            = state_reg.qcount - 4'h1;
         end
      end
      if (CLEAR_STATUS)
      begin
         state_next.qcount = 4'h0;
      end
      else if (ERR_PUSH && (state_next.qcount != QDEPTH_C))
      begin
         state_next.queue[state_next.qcount] = ERR_CODE_IN;
         state_next.qcount                   = state_next.qcount + 4'h1;
      end
      // summary bit follows enabled set events
      state_next.summary = |(state_next.event_status & state_next.event_status_enable);
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         state_reg                     <= '0;
         state_reg.event_status        <= EVENT_RST;
         state_reg.event_status_enable <= MASK_RST;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // outputs straight from flip-flops
   assign ANS_BCD       = state_reg.ans_bcd;
   assign ANS_VALID     = state_reg.ans_valid;
   assign ERR_CODE      = state_reg.err_code;
   assign ERR_VALID     = state_reg.err_valid;
   assign EVENT_SUMMARY = state_reg.summary;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);

   pon_set_a:     assert property (state_reg.pwr_sync |=> state_reg.event_status[BIT_PON])
      else $error("power flag not set");
   cme_set_a:     assert property (EVENTS.cmd_err |=> state_reg.event_status[BIT_CME])
      else $error("command error flag not set");
   dde_set_a:     assert property (EVENTS.dev_err |=> state_reg.event_status[BIT_DDE])
      else $error("device error flag not set");
   qye_set_a:     assert property ((EVENTS.talk_empty || EVENTS.unread_lost)
                                   |=> state_reg.event_status[BIT_QYE])
      else $error("query error flag not set");
   opc_fire_a:    assert property (OPC_CMD ##1 (EXEC_IDLE && IF_READY && !OPC_CMD)
                                   |=> state_reg.event_status[BIT_OPC])
      else $error("completion flag not set");
   read_clear_a:  assert property ((EVENT_READ && set_vec == 16'h0000) |=> state_reg.event_status == 16'h0000)
      else $error("event register kept after read");
   mask_keep_a:   assert property ((MASK_READ && !MASK_WRITE) |=> $stable(state_reg.event_status_enable))
      else $error("mask changed by read");
   answer_dec_a:  assert property (EVENT_READ |=> ANS_VALID && ANS_BCD == to_bcd($past(state_reg.event_status)))
      else $error("event answer wrong");
   zero_bits_a:   assert property ((state_reg.event_status & ~LIVE_MSK) == 16'h0000)
      else $error("reserved event bit set");
   queue_order_a: assert property ((ERR_FETCH && state_reg.qcount != 4'h0)
                                   |=> ERR_VALID && ERR_CODE == $past(state_reg.queue[0]))
      else $error("queue not oldest first");
   queue_cap_a:   assert property ((ERR_PUSH && !ERR_FETCH && !CLEAR_STATUS && state_reg.qcount == QDEPTH_C)
                                   |=> state_reg.qcount == QDEPTH_C && $stable(state_reg.queue))
      else $error("push accepted into full queue");
   summary_a:     assert property (##1 EVENT_SUMMARY ==
                                   |($past(state_next.event_status) & $past(state_next.event_status_enable)))
      else $error("summary bit wrong");

   read_event_c:  cover property (EVENT_READ ##1 ANS_VALID && ANS_BCD != 20'h00000);
   queue_full_c:  cover property (state_reg.qcount == QDEPTH_C);
   summary_c:     cover property (EVENT_SUMMARY ##1 EVENT_READ);
   opc_done_c:    cover property (opc_fire);
endmodule

// ---- bench/remote_host_model.sv ----
/*
 * remote_host_model: remote controller that sends the two read queries.
 * assumes: shares the core clock and drives its strobes at falling edges.
 */
`timescale 1ns/10ps
module remote_host_model (
   // clock
   input  wire logic        clk,
   // query strobes
   output logic             event_read,
   output logic             mask_read,
   // answer
   input  wire logic [19:0] ans_bcd,
   input  wire logic        ans_valid
);
   // one query pulse; answer and its strobe are taken a cycle later
   task automatic query(input logic sel_mask, output logic [20:0] ans);
      @(negedge clk);
      event_read = !sel_mask;
      mask_read  = sel_mask;
      @(negedge clk);
      event_read = 1'b0;
      mask_read  = 1'b0;
      ans        = {ans_valid, ans_bcd};
   endtask

   // idle strobes from time zero
   initial
   begin
      event_read = 1'b0;
      mask_read  = 1'b0;
   end
endmodule

// ---- bench/event_status_register_bank_tb.sv ----
/*
 * event_status_register_bank_tb: self-checking bench for the event bank.
 * assumes: remote_host_model sends the queries; inputs change at falling edges.
 */
`timescale 1ns/10ps
module event_status_register_bank_tb;
   import evstat_pkg::*;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic        core_clk, rstn, pwr_cycled, opc_cmd, exec_idle, if_ready;
   logic        event_read, mask_read, mask_write, clear_status;
   logic        err_push, err_fetch, ans_valid, err_valid, event_summary;
   logic [15:0] mask_wdata;
   logic [7:0]  err_code_in, err_code;
   logic [19:0] ans_bcd;
   logic [20:0] ans;
   event_in_s   events;
   int          n_fail, compares;

   event_status_register_bank u_dut (.CORE_CLK(core_clk), .RSTN(rstn), .PWR_CYCLED(pwr_cycled),
      .EVENTS(events), .OPC_CMD(opc_cmd), .EXEC_IDLE(exec_idle), .IF_READY(if_ready),
      .EVENT_READ(event_read), .MASK_READ(mask_read), .MASK_WRITE(mask_write),
      .MASK_WDATA(mask_wdata), .CLEAR_STATUS(clear_status), .ERR_PUSH(err_push),
      .ERR_CODE_IN(err_code_in), .ERR_FETCH(err_fetch), .ANS_BCD(ans_bcd),
      .ANS_VALID(ans_valid), .ERR_CODE(err_code), .ERR_VALID(err_valid),
      .EVENT_SUMMARY(event_summary));
   remote_host_model u_host (.clk(core_clk), .event_read(event_read), .mask_read(mask_read),
      .ans_bcd(ans_bcd), .ans_valid(ans_valid));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // five decimal digits of a value
   function automatic logic [19:0] to_bcd(input int v);
      logic [19:0] r;
      for (int i = 0; i < 5; i++)
      begin
         r[4*i+:4] = 4'(v % 10);
         v         = v / 10;
      end
      return r;
   endfunction

   task automatic chk(input string name, input logic [20:0] exp, input logic [20:0] got);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic read_reg(input logic sel_mask, input int exp);
      u_host.query(sel_mask, ans);
      chk(sel_mask ? "mask" : "event", {1'b1, to_bcd(exp)}, ans);
   endtask

   task automatic pulse_ev(input event_in_s e);
      @(negedge core_clk) events = e;
      @(negedge core_clk) events = '0;
   endtask

   task automatic write_mask(input logic [15:0] v);
      @(negedge core_clk);
      mask_write = 1'b1;
      mask_wdata = v;
      @(negedge core_clk) mask_write = 1'b0;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // every condition strobe alone, then all together, then read-clear
   task automatic t_errors;
      int ev_exp[5] = '{4, 4, 8, 16, 32};
      for (int i = 0; i < 5; i++)
      begin
         pulse_ev(event_in_s'(5'(1 << i)));
         read_reg(1'b0, ev_exp[i]);
      end
      pulse_ev('1);
      read_reg(1'b0, 60);
      read_reg(1'b0, 0);
   endtask

   // mask kept on read, summary follows enabled bits only
   task automatic t_mask;
      write_mask(16'hFFFF);
      read_reg(1'b1, 65535);
      read_reg(1'b1, 65535);
      write_mask(16'h0020);
      pulse_ev(event_in_s'(5'h08));
      chk("summary", 21'h0, {20'h0, event_summary});
      pulse_ev(event_in_s'(5'h10));
      chk("summary", 21'h1, {20'h0, event_summary});
      read_reg(1'b0, 48);
      chk("summary", 21'h0, {20'h0, event_summary});
   endtask

   // power cycle and operation complete together, upper byte zero
   task automatic t_pon_opc;
      @(negedge core_clk);
      exec_idle  = 1'b1;
      if_ready   = 1'b1;
      opc_cmd    = 1'b1;
      pwr_cycled = 1'b1;
      @(negedge core_clk);
      opc_cmd    = 1'b0;
      pwr_cycled = 1'b0;
      repeat (4) @(negedge core_clk);
      read_reg(1'b0, 129);
   endtask

   // sixteen pushes back to back; only the first fifteen are kept
   task automatic t_queue;
      for (int i = 1; i <= 16; i++)
      begin
         @(negedge core_clk);
         err_push    = 1'b1;
         err_code_in = 8'(i);
      end
      @(negedge core_clk) err_push = 1'b0;
      for (int i = 0; i < 16; i++)
      begin
         @(negedge core_clk) err_fetch = 1'b1;
         @(negedge core_clk) err_fetch = 1'b0;
         chk("code", {1'b1, 12'h000, 8'(i < 15 ? i + 1 : 0)}, {err_valid, 12'h000, err_code});
      end
   endtask

   // clear-status empties both the event register and the error queue
   task automatic t_clear;
      @(negedge core_clk);
      err_push     = 1'b1;
      err_code_in  = 8'h2A;
      events       = event_in_s'(5'h10);
      @(negedge core_clk);
      err_push     = 1'b0;
      events       = '0;
      clear_status = 1'b1;
      @(negedge core_clk) clear_status = 1'b0;
      read_reg(1'b0, 0);
      @(negedge core_clk) err_fetch = 1'b1;
      @(negedge core_clk) err_fetch = 1'b0;
      chk("code", {1'b1, 12'h000, CODE_NONE}, {err_valid, 12'h000, err_code});
   endtask

   task automatic stop_test;
      if (n_fail == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // clock, watchdog, main sequence
   // ----------------------------------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   initial
   begin
      #(25 * 3000);
      n_fail++;
      stop_test();
   end

   initial
   begin
      {rstn, pwr_cycled, opc_cmd, exec_idle, if_ready, mask_write} = '0;
      {clear_status, err_push, err_fetch, mask_wdata, err_code_in} = '0;
      events = '0;
      n_fail = 0;
      compares = 0;
      repeat (6) @(posedge core_clk);
      @(negedge core_clk) rstn = 1'b1;
      read_reg(1'b0, 0);
      read_reg(1'b1, 0);
      t_errors();
      t_mask();
      t_pon_opc();
      t_queue();
      t_clear();
      stop_test();
   end
endmodule
